// *** verilog/alxe_core.sv ***
// Execution core for set-bit, short jump, subtract with borrow, nibble
// swap, byte and digit exchange, and exclusive-OR.
// Assumes program memory answers combinationally on pmem_addr.
//
// Notes on behaviour
// - set-bit forces carry or bit, flags unchanged
// - short jump always branches, no condition
// - jump target is pc plus two plus displacement
// - displacement is signed byte, -128 to +127
// - accumulator minus source minus carry
// - carry reports borrow out of bit 7
// - auxiliary carry reports borrow from bit 3
// - overflow is borrow out of bit 6 xor borrow out of bit 7
// - subtract source: register, direct, indirect, immediate
// - swap exchanges accumulator nibbles, no flags
// - exchange swaps accumulator and operand together
// - exchange operand: register, direct or indirect
// - digit exchange swaps low nibbles with indirect byte
// - upper nibbles and flags kept on digit exchange
// - exclusive-OR combines operands bitwise
// - result to destination, flags untouched
// - accumulator destination takes four source forms
// - direct destination takes accumulator or immediate mask
// - port operand read from output latch for direct destination; accumulator destination reads the pins
module alxe_core #(
    parameter int unsigned RAM_DEPTH = alxe_pkg::RAM_DEPTH
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    output logic [alxe_pkg::PC_W-1:0]      pmem_addr,
    input  wire logic [alxe_pkg::DATA_W-1:0] pmem_data,
    input  wire logic [alxe_pkg::DATA_W-1:0] port1_pins_in,
    output logic [alxe_pkg::DATA_W-1:0]    port1_latch_out,
    output logic [alxe_pkg::DATA_W-1:0]    acc_out,
    output logic [alxe_pkg::DATA_W-1:0]    psw_out,
    output logic                           instr_done,
    output logic [1:0]                     instr_bytes,
    output logic [1:0]                     instr_cycles,
    output logic                           illegal_op
);
    ////////////////////////////////////////////////////////////////////////
    // State
    alxe_pkg::alxe_state_t state_reg, state_next;
    logic [15:0] pc_reg, pc_next;
    logic [7:0]  op_reg, b2_reg, b3_reg;
    logic [7:0]  acc_reg, acc_next;
    logic [7:0]  psw_reg, psw_next;
    logic [7:0]  port_reg, port_next;
    logic        done_reg;
    logic        illegal_reg;
    logic [1:0]  bytes_reg;
    logic [1:0]  cycles_reg;

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode
    wire [7:0] op = op_reg;
    wire is_setc     = (op == alxe_pkg::OP_SETC);
    wire is_setbit   = (op == alxe_pkg::OP_SETBIT);
    wire is_jrel     = (op == alxe_pkg::OP_JREL);
    wire is_sbr_reg  = (op[7:3] == alxe_pkg::OP_SBR_REG_HI);
    wire is_sbr_dir  = (op == alxe_pkg::OP_SBR_DIR);
    wire is_sbr_ind  = (op[7:1] == alxe_pkg::OP_SBR_IND_HI);
    wire is_sbr_imm  = (op == alxe_pkg::OP_SBR_IMM);
    wire is_swap     = (op == alxe_pkg::OP_SWAP);
    wire is_exb_reg  = (op[7:3] == alxe_pkg::OP_EXB_REG_HI);
    wire is_exb_dir  = (op == alxe_pkg::OP_EXB_DIR);
    wire is_exb_ind  = (op[7:1] == alxe_pkg::OP_EXB_IND_HI);
    wire is_exd      = (op[7:1] == alxe_pkg::OP_EXD_HI);
    wire is_eor_reg  = (op[7:3] == alxe_pkg::OP_EOR_REG_HI);
    wire is_eor_dir  = (op == alxe_pkg::OP_EOR_DIR);
    wire is_eor_ind  = (op[7:1] == alxe_pkg::OP_EOR_IND_HI);
    wire is_eor_imm  = (op == alxe_pkg::OP_EOR_IMM);
    wire is_eor_da   = (op == alxe_pkg::OP_EOR_DIR_A);
    wire is_eor_di   = (op == alxe_pkg::OP_EOR_DIR_IM);

    wire is_sbr   = is_sbr_reg | is_sbr_dir | is_sbr_ind | is_sbr_imm;
    wire is_exb   = is_exb_reg | is_exb_dir | is_exb_ind;
    wire is_eor_a = is_eor_reg | is_eor_dir | is_eor_ind | is_eor_imm;
    wire is_eor_m = is_eor_da | is_eor_di;
    wire is_ind   = is_sbr_ind | is_exb_ind | is_exd | is_eor_ind;
    wire is_dir   = is_sbr_dir | is_exb_dir | is_eor_dir | is_eor_m;
    wire is_imm   = is_sbr_imm | is_eor_imm;
    wire is_known = is_setc | is_setbit | is_jrel | is_sbr | is_swap
                  | is_exb | is_exd | is_eor_a | is_eor_m;

    ////////////////////////////////////////////////////////////////////////
    // Instruction length from the byte on the fetch bus; reported length and cycles from the latched opcode
    wire [7:0] fb = pmem_data;
    wire fb_len3 = (fb == alxe_pkg::OP_EOR_DIR_IM);
    wire fb_len2 = (fb == alxe_pkg::OP_SETBIT) | (fb == alxe_pkg::OP_JREL)
                 | (fb == alxe_pkg::OP_SBR_DIR) | (fb == alxe_pkg::OP_SBR_IMM)
                 | (fb == alxe_pkg::OP_EXB_DIR) | (fb == alxe_pkg::OP_EOR_DIR)
                 | (fb == alxe_pkg::OP_EOR_IMM) | (fb == alxe_pkg::OP_EOR_DIR_A)
                 | fb_len3;

    wire [1:0] exec_len = is_eor_di ? alxe_pkg::LEN_3 :
                          (is_setbit | is_jrel | is_dir | is_imm)
                          ? alxe_pkg::LEN_2 : alxe_pkg::LEN_1;
    wire [1:0] exec_cyc = !is_known ? alxe_pkg::CYC_NONE :
                          (is_jrel | is_eor_di)
                          ? alxe_pkg::CYC_2 : alxe_pkg::CYC_1;

    ////////////////////////////////////////////////////////////////////////
    // Operand addressing
    wire [1:0] bank     = {psw_reg[alxe_pkg::PSW_RS1],
                           psw_reg[alxe_pkg::PSW_RS0]};
    wire [7:0] reg_addr = {3'h0, bank, op[2:0]};
    wire [7:0] ptr_addr = {3'h0, bank, 2'h0, op[0]};
    wire [7:0] ptr_val;
    wire [7:0] bit_byte = b2_reg[alxe_pkg::SFR_BIT]
                        ? {b2_reg[7:3], 3'h0}
                        : alxe_pkg::BIT_RAM_BASE + {4'h0, b2_reg[6:3]};
    wire [7:0] eff_addr = is_setbit   ? bit_byte :
                          is_dir      ? b2_reg   :
                          is_ind      ? ptr_val  : reg_addr;
    wire is_sfr  = (is_dir | is_setbit) & eff_addr[alxe_pkg::SFR_BIT];
    wire use_latch = is_eor_m | is_setbit;
    wire [7:0] port_rd = use_latch ? port_reg : port1_pins_in;
    wire [7:0] sfr_rd = (eff_addr == alxe_pkg::SFR_ACC)   ? acc_reg :
                        (eff_addr == alxe_pkg::SFR_PSW)   ? psw_reg :
                        (eff_addr == alxe_pkg::SFR_PORT1) ? port_rd :
                        alxe_pkg::ZERO_BYTE;
    wire [7:0] ram_rd;
    wire [7:0] loc_rd  = is_sfr ? sfr_rd : ram_rd;
    wire [7:0] imm_val = is_eor_di ? b3_reg : b2_reg;
    wire [7:0] src_val = is_imm ? imm_val : loc_rd;

    ////////////////////////////////////////////////////////////////////////
    // Data path
    wire [7:0] sub_res;
    wire       sub_cy, sub_aux, sub_ovf;
    wire [7:0] eor_mask = is_eor_da ? acc_reg : imm_val;
    wire [7:0] eor_acc  = acc_reg ^ src_val;
    wire [7:0] eor_mem  = loc_rd ^ eor_mask;
    wire [7:0] bit_set  = loc_rd | (8'h01 << b2_reg[2:0]);
    wire [7:0] exd_mem  = {loc_rd[7:4], acc_reg[3:0]};
    wire [7:0] exd_acc  = {acc_reg[7:4], loc_rd[3:0]};
    wire [7:0] swap_acc = {acc_reg[3:0], acc_reg[7:4]};
    wire [15:0] rel_ext = {{8{b2_reg[7]}}, b2_reg};
    wire [15:0] jmp_tgt = pc_reg + rel_ext;

    wire exec    = (state_reg == alxe_pkg::ST_EXEC);
    wire wr_loc  = exec & (is_exb | is_exd | is_eor_m | is_setbit);
    wire [7:0] wr_data = is_exb   ? acc_reg  :
                         is_exd   ? exd_mem  :
                         is_eor_m ? eor_mem  : bit_set;
    wire wr_ram  = wr_loc & ~is_sfr;
    wire wr_acc_sfr  = wr_loc & is_sfr & (eff_addr == alxe_pkg::SFR_ACC);
    wire wr_psw_sfr  = wr_loc & is_sfr & (eff_addr == alxe_pkg::SFR_PSW);
    wire wr_port_sfr = wr_loc & is_sfr & (eff_addr == alxe_pkg::SFR_PORT1);

    alxe_sub #(
        .W          (alxe_pkg::DATA_W)
    ) u_sub (
        .minuend    (acc_reg),
        .subtrahend (src_val),
        .borrow_in  (psw_reg[alxe_pkg::PSW_CY]),
        .difference (sub_res),
        .borrow_msb (sub_cy),
        .borrow_nib (sub_aux),
        .overflow   (sub_ovf)
    );

    alxe_iram #(
        .DEPTH      (RAM_DEPTH),
        .W          (alxe_pkg::DATA_W)
    ) u_iram (
        .core_clk   (core_clk),
        .wr_en      (wr_ram),
        .wr_addr    (eff_addr),
        .wr_data    (wr_data),
        .rd_addr_a  (ptr_addr),
        .rd_data_a  (ptr_val),
        .rd_addr_b  (eff_addr),
        .rd_data_b  (ram_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state selection
    always_comb begin
        state_next = state_reg;
        pc_next    = pc_reg;
        acc_next   = acc_reg;
        psw_next   = psw_reg;
        port_next  = port_reg;
        unique case (state_reg)
            alxe_pkg::ST_FETCH: begin
                pc_next    = pc_reg + 16'h0001;
                state_next = fb_len2 ? alxe_pkg::ST_BYTE2
                                     : alxe_pkg::ST_EXEC;
            end
            alxe_pkg::ST_BYTE2: begin
                pc_next    = pc_reg + 16'h0001;
                state_next = (op_reg == alxe_pkg::OP_EOR_DIR_IM)
                           ? alxe_pkg::ST_BYTE3 : alxe_pkg::ST_EXEC;
            end
            alxe_pkg::ST_BYTE3: begin
                pc_next    = pc_reg + 16'h0001;
                state_next = alxe_pkg::ST_EXEC;
            end
            alxe_pkg::ST_EXEC: begin
                state_next = alxe_pkg::ST_FETCH;
                if (is_jrel) begin
                    pc_next = jmp_tgt;
                end
                if (is_sbr) begin
                    acc_next = sub_res;
                    psw_next[alxe_pkg::PSW_CY] = sub_cy;
                    psw_next[alxe_pkg::PSW_AUX] = sub_aux;
                    psw_next[alxe_pkg::PSW_OVF] = sub_ovf;
                end
                if (is_setc) begin
                    psw_next[alxe_pkg::PSW_CY] = 1'b1;
                end
                if (is_swap) begin
                    acc_next = swap_acc;
                end
                if (is_exb) begin
                    acc_next = loc_rd;
                end
                if (is_exd) begin
                    acc_next = exd_acc;
                end
                if (is_eor_a) begin
                    acc_next = eor_acc;
                end
                if (wr_acc_sfr) begin
                    acc_next = wr_data;
                end
                if (wr_psw_sfr) begin
                    psw_next = wr_data;
                end
                if (wr_port_sfr) begin
                    port_next = wr_data;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= alxe_pkg::ST_FETCH;
            pc_reg    <= alxe_pkg::PC_RST;
            acc_reg   <= alxe_pkg::ACC_RST;
            psw_reg   <= alxe_pkg::PSW_RST;
            port_reg  <= alxe_pkg::PORT_RST;
        end else begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
            acc_reg   <= acc_next;
            psw_reg   <= psw_next;
            port_reg  <= port_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            op_reg <= alxe_pkg::ZERO_BYTE;
            b2_reg <= alxe_pkg::ZERO_BYTE;
            b3_reg <= alxe_pkg::ZERO_BYTE;
        end else begin
            if (state_reg == alxe_pkg::ST_FETCH) begin
                op_reg <= pmem_data;
            end
            if (state_reg == alxe_pkg::ST_BYTE2) begin
                b2_reg <= pmem_data;
            end
            if (state_reg == alxe_pkg::ST_BYTE3) begin
                b3_reg <= pmem_data;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_reg    <= 1'b0;
            illegal_reg <= 1'b0;
            bytes_reg   <= alxe_pkg::LEN_1;
            cycles_reg  <= alxe_pkg::CYC_NONE;
        end else begin
            done_reg    <= exec;
            illegal_reg <= exec & ~is_known;
            if (exec) begin
                bytes_reg  <= exec_len;
                cycles_reg <= exec_cyc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign pmem_addr       = pc_reg;
    assign port1_latch_out = port_reg;
    assign acc_out         = acc_reg;
    assign psw_out         = psw_reg;
    assign instr_done      = done_reg;
    assign instr_bytes     = bytes_reg;
    assign instr_cycles    = cycles_reg;
    assign illegal_op      = illegal_reg;

endmodule : alxe_core

// *** verilog/alxe_pkg.sv ***
// Shared constants for the accumulator logic and branch execution block.
// Assumes one core clock and a synchronous active-high reset.
package alxe_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned PC_W      = 16;
    localparam int unsigned RAM_DEPTH = 128;

    ////////////////////////////////////////////////////////////////////////
    // First-byte opcodes
    localparam logic [7:0] OP_SETC       = 8'hD3;
    localparam logic [7:0] OP_SETBIT     = 8'hD2;
    localparam logic [7:0] OP_JREL       = 8'h80;
    localparam logic [4:0] OP_SBR_REG_HI = 5'h13;
    localparam logic [7:0] OP_SBR_DIR    = 8'h95;
    localparam logic [6:0] OP_SBR_IND_HI = 7'h4B;
    localparam logic [7:0] OP_SBR_IMM    = 8'h94;
    localparam logic [7:0] OP_SWAP       = 8'hC4;
    localparam logic [4:0] OP_EXB_REG_HI = 5'h19;
    localparam logic [7:0] OP_EXB_DIR    = 8'hC5;
    localparam logic [6:0] OP_EXB_IND_HI = 7'h63;
    localparam logic [6:0] OP_EXD_HI     = 7'h6B;
    localparam logic [4:0] OP_EOR_REG_HI = 5'h0D;
    localparam logic [7:0] OP_EOR_DIR    = 8'h65;
    localparam logic [6:0] OP_EOR_IND_HI = 7'h33;
    localparam logic [7:0] OP_EOR_IMM    = 8'h64;
    localparam logic [7:0] OP_EOR_DIR_A  = 8'h62;
    localparam logic [7:0] OP_EOR_DIR_IM = 8'h63;

    ////////////////////////////////////////////////////////////////////////
    // Special register addresses and status-word bit positions
    localparam logic [7:0] SFR_ACC   = 8'hE0;
    localparam logic [7:0] SFR_PSW   = 8'hD0;
    localparam logic [7:0] SFR_PORT1 = 8'h90;
    localparam int unsigned PSW_CY   = 7;
    localparam int unsigned PSW_AUX  = 6;
    localparam int unsigned PSW_RS1  = 4;
    localparam int unsigned PSW_RS0  = 3;
    localparam int unsigned PSW_OVF  = 2;
    localparam int unsigned SFR_BIT  = 7;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;

    ////////////////////////////////////////////////////////////////////////
    // Reset values, lengths and machine-cycle counts
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [7:0]  PSW_RST   = 8'h00;
    localparam logic [7:0]  PORT_RST  = 8'hFF;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;
    localparam logic [1:0]  LEN_1     = 2'd1;
    localparam logic [1:0]  LEN_2     = 2'd2;
    localparam logic [1:0]  LEN_3     = 2'd3;
    localparam logic [1:0]  CYC_1     = 2'd1;
    localparam logic [1:0]  CYC_2     = 2'd2;
    localparam logic [1:0]  CYC_NONE  = 2'd0;

    typedef enum logic [1:0] {
        ST_FETCH,
        ST_BYTE2,
        ST_BYTE3,
        ST_EXEC
    } alxe_state_t;

endpackage : alxe_pkg

// *** verilog/alxe_sub.sv ***
// Subtract-with-borrow arithmetic and its three flags.
// Assumes purely combinational use by the execution core.
module alxe_sub #(
    parameter int unsigned W = 8
) (
    input  wire logic [W-1:0] minuend,
    input  wire logic [W-1:0] subtrahend,
    input  wire logic         borrow_in,
    output logic      [W-1:0] difference,
    output logic              borrow_msb,
    output logic              borrow_nib,
    output logic              overflow
);
    logic [W:0]   full_diff;
    logic [4:0]   nib_diff;
    logic [W-1:0] low_diff;

    assign full_diff  = {1'b0, minuend} - {1'b0, subtrahend}
                      - {{W{1'b0}}, borrow_in};
    assign nib_diff   = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]}
                      - {4'h0, borrow_in};
    assign low_diff   = {1'b0, minuend[W-2:0]} - {1'b0, subtrahend[W-2:0]}
                      - {{(W-1){1'b0}}, borrow_in};
    assign difference = full_diff[W-1:0];
    assign borrow_msb = full_diff[W];
    assign borrow_nib = nib_diff[4];
    assign overflow   = full_diff[W] ^ low_diff[W-1];

endmodule : alxe_sub

// *** verilog/alxe_iram.sv ***
// Internal data RAM: one synchronous write port, two combinational reads.
// Assumes addresses below DEPTH; upper address bits are ignored.
module alxe_iram #(
    parameter int unsigned DEPTH = 128,
    parameter int unsigned W     = 8
) (
    input  wire logic         core_clk,
    input  wire logic         wr_en,
    input  wire logic [7:0]   wr_addr,
    input  wire logic [W-1:0] wr_data,
    input  wire logic [7:0]   rd_addr_a,
    output logic      [W-1:0] rd_data_a,
    input  wire logic [7:0]   rd_addr_b,
    output logic      [W-1:0] rd_data_b
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];

    assign rd_data_a = mem[rd_addr_a[AW-1:0]];
    assign rd_data_b = mem[rd_addr_b[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr[AW-1:0]] <= wr_data;
        end
    end

endmodule : alxe_iram

// *** bench/alxe_pmem_model.sv ***
// Program memory model: answers combinationally on the fetch address.
// Assumes the bench fills mem by hierarchical writes while reset holds.
module alxe_pmem_model (
    input  wire logic [15:0] pmem_addr,
    output logic      [7:0]  pmem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    // Beyond the loaded page a changing pattern, never a held value
    assign pmem_data = (pmem_addr[15:8] == 8'h00) ? mem[pmem_addr[7:0]]
                                                  : ~pmem_addr[7:0];
endmodule : alxe_pmem_model

// *** bench/alxe_core_sva.sv ***
// Port checker for the execution core, attached by bind.
// Assumes one clock and the synchronous active-high reset.
module alxe_core_chk (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [15:0] pmem_addr,
    input wire logic [7:0]  pmem_data,
    input wire logic [7:0]  acc_out,
    input wire logic [7:0]  psw_out,
    input wire logic        instr_done,
    input wire logic [1:0]  instr_bytes,
    input wire logic [1:0]  instr_cycles,
    input wire logic        illegal_op
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic [15:0] rel_ext = {{8{pmem_data[7]}}, pmem_data};
    wire logic [7:0]  acc_sw  = {acc_out[3:0], acc_out[7:4]};
    wire logic [3:0]  acc_hi  = acc_out[7:4];
    wire logic        cy      = psw_out[alxe_pkg::PSW_CY];
    wire logic [8:0]  acc9    = {1'b0, acc_out};
    wire logic [8:0]  src9    = {1'b0, pmem_data};
    wire logic [8:0]  cin9    = {8'h00, cy};
    // Opcode taken in the cycle that reports the previous completion
    sequence fetch_of(logic [7:0] op);
        instr_done && pmem_data == op;
    endsequence
    a_done_pulse: assert property (
        instr_done |=> !instr_done) else $error("done held");
    a_illegal_len: assert property (
        illegal_op |-> instr_done && instr_bytes == alxe_pkg::LEN_1
        && instr_cycles == alxe_pkg::CYC_NONE) else $error("illegal len");
    a_jump_target: assert property (
        instr_done && instr_bytes == alxe_pkg::LEN_2
        && instr_cycles == alxe_pkg::CYC_2 |-> pmem_addr ==
        $past(pmem_addr, 3) + 16'h0002 + $past(rel_ext, 2))
        else $error("jump target");
    a_swap_nibbles: assert property (
        fetch_of(alxe_pkg::OP_SWAP) |=> ##1 instr_done
        && acc_out == $past(acc_sw, 2) && psw_out == $past(psw_out, 2))
        else $error("swap");
    a_set_carry: assert property (
        fetch_of(alxe_pkg::OP_SETC) |=> ##1
        psw_out == ($past(psw_out, 2) | 8'h80)) else $error("set carry");
    a_digit_keep: assert property (
        instr_done && pmem_data[7:1] == alxe_pkg::OP_EXD_HI |=> ##1
        psw_out == $past(psw_out, 2) && acc_hi == $past(acc_hi, 2))
        else $error("digit exchange");
    a_xor_flags: assert property (
        instr_done && pmem_data[7:4] == 4'h6 && pmem_data[3:2] != 2'b00
        |=> $stable(psw_out) [*3]) else $error("xor flags");
    a_sbr_value: assert property (
        fetch_of(alxe_pkg::OP_SBR_IMM) |=> ##2 {cy, acc_out} ==
        $past(acc9, 3) - $past(src9, 2) - $past(cin9, 3))
        else $error("subtract");
endmodule : alxe_core_chk

bind alxe_core alxe_core_chk chk_u (
    .core_clk(core_clk), .rst(rst), .pmem_addr(pmem_addr),
    .pmem_data(pmem_data), .acc_out(acc_out), .psw_out(psw_out),
    .instr_done(instr_done), .instr_bytes(instr_bytes),
    .instr_cycles(instr_cycles), .illegal_op(illegal_op));

// *** bench/tb.sv ***
// Self-checking bench for the execution core and its program memory.
// Assumes internal RAM may be preloaded through the core's RAM instance.
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  port1_pins_in = 8'h00;
    logic [15:0] pmem_addr;
    logic [7:0]  pmem_data, port1_latch_out, acc_out, psw_out;
    logic        instr_done, illegal_op;
    logic [1:0]  instr_bytes, instr_cycles;
    int          fails = 0;
    int          tests_run = 0;
    always #2.5 core_clk = ~core_clk;
    alxe_core dut_u (.core_clk(core_clk), .rst(rst), .pmem_addr(pmem_addr),
        .pmem_data(pmem_data), .port1_pins_in(port1_pins_in),
        .port1_latch_out(port1_latch_out), .acc_out(acc_out),
        .psw_out(psw_out), .instr_done(instr_done),
        .instr_bytes(instr_bytes), .instr_cycles(instr_cycles),
        .illegal_op(illegal_op));
    alxe_pmem_model pmem_u (.pmem_addr(pmem_addr), .pmem_data(pmem_data));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // Holds reset and places a program with a trap loop behind it
    task automatic load(input logic [7:0] p [$]);
        @(posedge core_clk);
        #1;
        rst = 1'b1;
        foreach (p[i]) pmem_u.mem[i] = p[i];
        pmem_u.mem[p.size()] = 8'h80;
        pmem_u.mem[p.size()+1] = 8'hFE;
    endtask : load
    task automatic ram(input int a, input logic [7:0] v);
        dut_u.u_iram.mem[a] = v;
    endtask : ram
    task automatic go();
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
    endtask : go
    task automatic step(input logic [1:0] b, c);
        int n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (instr_done !== 1'b1 && n < 20);
        if (instr_done !== 1'b1) begin
            fails++;
            $display("ERROR t=%0t no completion", $time);
            test_done();
        end
        `CHK(instr_bytes, b)
        `CHK(instr_cycles, c)
    endtask : step
    task automatic run(input logic [1:0] b, c, input logic [7:0] ea, ep);
        step(b, c);
        `CHK(acc_out, ea)
        `CHK(psw_out, ep)
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    task automatic t_setbit();
        load('{8'h63, 8'h90, 8'hCB, 8'hD3, 8'hD2, 8'h90});
        go();
        step(2'd3, 2'd2);
        `CHK(port1_latch_out, 8'h34)
        run(2'd1, 2'd1, 8'h00, 8'h80);
        run(2'd2, 2'd1, 8'h00, 8'h80);
        `CHK(port1_latch_out, 8'h35)
        $display("test set bit finished");
    endtask : t_setbit
    task automatic t_jrel();
        load('{8'h80, 8'h7F, 8'h00, 8'h80, 8'hFE});
        pmem_u.mem[8'h81] = 8'h80;
        pmem_u.mem[8'h82] = 8'h80;
        go();
        step(2'd2, 2'd2);
        `CHK(pmem_addr, 16'h0081)
        step(2'd2, 2'd2);
        `CHK(pmem_addr, 16'h0003)
        step(2'd2, 2'd2);
        `CHK(pmem_addr, 16'h0003)
        $display("test short jump finished");
    endtask : t_jrel
    task automatic t_sbr();
        load('{8'hD3, 8'h64, 8'hC9, 8'h9A, 8'h94, 8'h75, 8'h95, 8'h30,
               8'h97});
        ram(2, 8'h54);
        ram(8'h30, 8'h0F);
        ram(1, 8'h31);
        ram(8'h31, 8'h70);
        go();
        run(2'd1, 2'd1, 8'h00, 8'h80);
        run(2'd2, 2'd1, 8'hC9, 8'h80);
        run(2'd1, 2'd1, 8'h74, 8'h04);
        run(2'd2, 2'd1, 8'hFF, 8'hC0);
        run(2'd2, 2'd1, 8'hEF, 8'h40);
        run(2'd1, 2'd1, 8'h7F, 8'h04);
        $display("test subtract finished");
    endtask : t_sbr
    task automatic t_exch();
        load('{8'h64, 8'hC5, 8'hC4, 8'hCB, 8'hC6, 8'hC5, 8'h40, 8'hC5,
               8'h90});
        ram(3, 8'h11);
        ram(0, 8'h20);
        ram(8'h20, 8'h75);
        ram(8'h40, 8'hAA);
        port1_pins_in = 8'h5A;
        go();
        run(2'd2, 2'd1, 8'hC5, 8'h00);
        run(2'd1, 2'd1, 8'h5C, 8'h00);
        run(2'd1, 2'd1, 8'h11, 8'h00);
        `CHK(dut_u.u_iram.mem[3], 8'h5C)
        run(2'd1, 2'd1, 8'h75, 8'h00);
        `CHK(dut_u.u_iram.mem[8'h20], 8'h11)
        run(2'd2, 2'd1, 8'hAA, 8'h00);
        `CHK(dut_u.u_iram.mem[8'h40], 8'h75)
        run(2'd2, 2'd1, 8'h5A, 8'h00);
        `CHK(port1_latch_out, 8'hAA)
        $display("test exchange finished");
    endtask : t_exch
    task automatic t_exd();
        load('{8'hD3, 8'h64, 8'h36, 8'hD6, 8'hD7});
        ram(0, 8'h20);
        ram(1, 8'h21);
        ram(8'h20, 8'h75);
        ram(8'h21, 8'hA9);
        go();
        run(2'd1, 2'd1, 8'h00, 8'h80);
        run(2'd2, 2'd1, 8'h36, 8'h80);
        run(2'd1, 2'd1, 8'h35, 8'h80);
        `CHK(dut_u.u_iram.mem[8'h20], 8'h76)
        run(2'd1, 2'd1, 8'h39, 8'h80);
        `CHK(dut_u.u_iram.mem[8'h21], 8'hA5)
        $display("test digit exchange finished");
    endtask : t_exd
    task automatic t_eor();
        load('{8'hD3, 8'h64, 8'hC3, 8'h68, 8'h65, 8'h50, 8'h67, 8'h62,
               8'h52, 8'hA5});
        ram(0, 8'hAA);
        ram(1, 8'h51);
        ram(8'h50, 8'h0F);
        ram(8'h51, 8'hF0);
        ram(8'h52, 8'hFF);
        go();
        run(2'd1, 2'd1, 8'h00, 8'h80);
        run(2'd2, 2'd1, 8'hC3, 8'h80);
        run(2'd1, 2'd1, 8'h69, 8'h80);
        run(2'd2, 2'd1, 8'h66, 8'h80);
        run(2'd1, 2'd1, 8'h96, 8'h80);
        run(2'd2, 2'd1, 8'h96, 8'h80);
        `CHK(dut_u.u_iram.mem[8'h52], 8'h69)
        step(2'd1, 2'd0);
        `CHK(illegal_op, 1'b1)
        `CHK(acc_out, 8'h96)
        $display("test xor finished");
    endtask : t_eor
    initial begin
        t_setbit();
        t_jrel();
        t_sbr();
        t_exch();
        t_exd();
        t_eor();
        test_done();
    end
endmodule : tb
